/* File: hdl/timer8_shared_prescaler.v */
// 8-bit timer/counter with shared prescaler and APB register slave
`timescale 1ns/1ps
`include "timer8_regs.vh"
module timer8_shared_prescaler #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             clk,
    input  wire             sys_rst,
    // APB slave
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [11:0]      paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output reg              pready,
    output reg              pslverr,
    // Pins and core events
    input  wire             extCountInput,
    input  wire             sleepMode,
    input  wire             watchdogClearOp,
    // Outputs
    output reg              overflowIrq,
    output reg              irqOut,
    output reg              wdtTick
);
    reg [WIDTH-1:0] countValue_r;
    reg [7:0]       optionConfig_r;
    reg [7:0]       intControl_r;
    reg [1:0]       control_r;
    reg [0:0]       irqStatus_r;
    reg [0:0]       irqMask_r;
    reg [1:0]       qPhase_r;
    reg [2:0]       pinSync_r;
    reg             pinLevel_r;
    reg             tapQ2_r;
    reg             tapQ4_r;
    reg [1:0]       holdCnt_r;
    reg             prevTap_r;

    wire            srcIsPin   = optionConfig_r[`OPT_SRC_BIT];
    wire            edgeFall   = optionConfig_r[`OPT_EDGE_BIT];
    wire            toWatchdog = optionConfig_r[`OPT_ASSIGN_BIT];
    wire [2:0]      rateSel    = optionConfig_r[`OPT_RATE_HI:`OPT_RATE_LO];
    wire            sleeping   = sleepMode | control_r[`CTRL_SLEEP_BIT];
    wire            access     = psel & penable;
    wire            wrAcc      = access & pwrite;
    wire            rdAcc      = access & ~pwrite;

    // One enable per instruction cycle; four phase slots
    wire            instrTick  = (qPhase_r == 2'h3);
    wire            phaseQ2    = (qPhase_r == 2'h1);
    wire            phaseQ4    = (qPhase_r == 2'h3);

    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `ADDR_COUNT_VALUE) || (a == `ADDR_INT_CONTROL) ||
                     (a == `ADDR_OPTION_CONFIG) || (a == `ADDR_CONTROL) ||
                     (a == `ADDR_IRQ_STATUS) || (a == `ADDR_IRQ_MASK);
        end
    endfunction

    wire wrCount  = wrAcc & (paddr == `ADDR_COUNT_VALUE);
    wire wrIntc   = wrAcc & (paddr == `ADDR_INT_CONTROL);
    wire wrOption = wrAcc & (paddr == `ADDR_OPTION_CONFIG);
    wire wrCtrl   = wrAcc & (paddr == `ADDR_CONTROL);
    wire wrStat   = wrAcc & (paddr == `ADDR_IRQ_STATUS);
    wire wrMask   = wrAcc & (paddr == `ADDR_IRQ_MASK);
    wire wdtClr   = watchdogClearOp | (wrCtrl & pwdata[`CTRL_WDTCLR_BIT]);

    // Pin path: three flops, change counts when second and third agree
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinSync_r  <= 3'h0;
            pinLevel_r <= 1'b0;
            qPhase_r   <= 2'h0;
        end else begin
            pinSync_r <= {pinSync_r[1:0], extCountInput};
            if (pinSync_r[1] == pinSync_r[2])
                pinLevel_r <= pinSync_r[2];
            qPhase_r <= qPhase_r + 2'h1;
        end
    end

    // Edge select on the filtered pin level
    reg  pinPrev_r;
    wire pinEdge = edgeFall ? (pinPrev_r & ~pinLevel_r)
                            : (~pinPrev_r & pinLevel_r);
    wire srcTick = srcIsPin ? pinEdge : instrTick;

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            pinPrev_r <= 1'b0;
        else
            pinPrev_r <= pinLevel_r;
    end

    wire timerTap;
    wire wdtTapW;
    wire preClear = (wrCount & ~toWatchdog) |
                    (wdtClr & toWatchdog);

    timer8_prescaler #(
        .WIDTH      (WIDTH)
    ) uPrescaler (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .srcTick    (srcTick & ~(sleeping & ~toWatchdog)),
        .clearCount (preClear),
        .rateSel    (rateSel),
        .toWatchdog (toWatchdog),
        .timerTap   (timerTap),
        .wdtTap     (wdtTapW)
    );

    // Undivided source when prescaler belongs to the watchdog
    wire rawTap = toWatchdog ? srcTick : timerTap;

    // Pin source keeps a level: a one-cycle edge pulse could slip past Q2
    wire pinTap = toWatchdog ? (pinLevel_r ^ edgeFall) : timerTap;

    // Pin-driven path resampled on Q2 and Q4 to align with the core
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tapQ2_r <= 1'b0;
            tapQ4_r <= 1'b0;
        end else begin
            if (phaseQ2)
                tapQ2_r <= pinTap;
            if (phaseQ4)
                tapQ4_r <= tapQ2_r;
        end
    end

    // Internal source uses the tap directly; pin source uses synced tap
    wire tapLevel = srcIsPin ? tapQ4_r : rawTap;
    // Divided taps change after the tick, so count their rising edge
    wire advance  = (toWatchdog & ~srcIsPin) ? srcTick
                                             : (tapLevel & ~prevTap_r);
    wire incEn = advance & ~sleeping & (holdCnt_r == 2'h0);
    wire rollover = incEn & (countValue_r == {WIDTH{1'b1}});

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prevTap_r    <= 1'b0;
            countValue_r <= {WIDTH{1'b0}};
            holdCnt_r    <= 2'h0;
        end else begin
            prevTap_r <= tapLevel;
            if (wrCount) begin
                countValue_r <= pwdata[WIDTH-1:0];
                holdCnt_r    <= `WRITE_HOLD_CYCLES;
            end else begin
                if (incEn)
                    countValue_r <= countValue_r + 1'b1;
                if (instrTick && holdCnt_r != 2'h0)
                    holdCnt_r <= holdCnt_r - 2'h1;
            end
        end
    end

    // Registers; hardware set wins over software clear
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            optionConfig_r <= `OPTION_RESET;
            intControl_r   <= `INTC_RESET;
            control_r      <= 2'h0;
            irqStatus_r    <= 1'b0;
            irqMask_r      <= 1'b0;
        end else begin
            if (wrOption)
                optionConfig_r <= pwdata[7:0];
            if (wrIntc)
                intControl_r <= pwdata[7:0];
            if (rollover)
                intControl_r[`INTC_FLAG_BIT] <= 1'b1;
            if (wrCtrl)
                control_r <= {1'b0, pwdata[`CTRL_SLEEP_BIT]};
            if (wrMask)
                irqMask_r <= pwdata[0];
            if (rollover)
                irqStatus_r <= 1'b1;
            else if (wrStat && pwdata[0])
                irqStatus_r <= 1'b0;
        end
    end

    // Outputs from flops; APB answers with no wait state
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata      <= 32'h0;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            overflowIrq <= 1'b0;
            irqOut      <= 1'b0;
            wdtTick     <= 1'b0;
        end else begin
            pready     <= psel & ~penable;
            pslverr    <= psel & ~penable & ~mapped(paddr);
            prdata     <= 32'h0;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `ADDR_COUNT_VALUE:   prdata <= {24'h0, countValue_r};
                    `ADDR_INT_CONTROL:   prdata <= {24'h0, intControl_r};
                    `ADDR_OPTION_CONFIG: prdata <= {24'h0, optionConfig_r};
                    `ADDR_CONTROL:       prdata <= {31'h0, control_r[0]};
                    `ADDR_IRQ_STATUS:    prdata <= {31'h0, irqStatus_r};
                    `ADDR_IRQ_MASK:      prdata <= {31'h0, irqMask_r};
                    default:             prdata <= 32'h0;
                endcase
            end
            overflowIrq <= intControl_r[`INTC_FLAG_BIT] &
                           intControl_r[`INTC_EN_BIT];
            irqOut      <= irqStatus_r[0] & irqMask_r[0];
            wdtTick     <= wdtTapW & toWatchdog;
        end
    end
endmodule

/* File: hdl/timer8_regs.vh */
// Register offsets, field positions, reset values and timing counts
`ifndef TIMER8_REGS_VH
`define TIMER8_REGS_VH
`define ADDR_COUNT_VALUE   12'h000
`define ADDR_INT_CONTROL   12'h004
`define ADDR_OPTION_CONFIG 12'h008
`define ADDR_CONTROL       12'h00C
`define ADDR_IRQ_STATUS    12'h010
`define ADDR_IRQ_MASK      12'h014
`define OPT_SRC_BIT        5
`define OPT_EDGE_BIT       4
`define OPT_ASSIGN_BIT     3
`define OPT_RATE_HI        2
`define OPT_RATE_LO        0
`define INTC_EN_BIT        5
`define INTC_FLAG_BIT      2
`define CTRL_SLEEP_BIT     0
`define CTRL_WDTCLR_BIT    1
`define OPTION_RESET       8'hFF
`define INTC_RESET         8'h00
`define QPHASES            4
`define WRITE_HOLD_CYCLES  2'h2
`endif

/* File: hdl/timer8_prescaler.v */
// Shared 8-bit prescaler counter with rate tap selection
`timescale 1ns/1ps
module timer8_prescaler #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             clk,
    input  wire             sys_rst,
    // Control
    input  wire             srcTick,
    input  wire             clearCount,
    input  wire [2:0]       rateSel,
    input  wire             toWatchdog,
    // Outputs
    output reg              timerTap,
    output reg              wdtTap
);
    reg [WIDTH-1:0] preCount_r;

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            preCount_r <= {WIDTH{1'b0}};
        end else if (clearCount) begin
            preCount_r <= {WIDTH{1'b0}};
        end else if (srcTick) begin
            preCount_r <= preCount_r + 1'b1;
        end
    end

    always @* begin
        timerTap = preCount_r[rateSel];
        wdtTap   = 1'b0;
        if (toWatchdog) begin
            timerTap = 1'b0;
            // WDT rate 000 is 1:1, so tap below bit 0 is the tick itself
            if (rateSel == 3'h0)
                wdtTap = srcTick;
            else
                wdtTap = preCount_r[rateSel - 3'h1];
        end
    end
endmodule

/* File: dv/ext_pulse_src.sv */
// Model of the pulse source on the external count pin
`timescale 1ns/1ps
module ext_pulse_src #(
    parameter HALF = 12
) (
    // Clock and pin
    input  wire logic clk,
    output logic      pin
);
    initial pin = 1'h0;
    // Levels held three instruction cycles so phase sampling sees each
    task automatic toggle(input int n);
        repeat (n) begin
            repeat (HALF) @(posedge clk);
            pin <= ~pin;
        end
    endtask
endmodule

/* File: dv/timer8_shared_prescaler_monitor.sv */
// Checker of the bus handshake and interrupt outputs of the timer
`timescale 1ns/1ps
module timer8_shared_prescaler_monitor #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // Bus and interrupts
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        overflowIrq,
    input wire logic        irqOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable && pready; endsequence
    property p_answer; s_setup |=> s_access; endproperty
    a_answer: assert property (p_answer) else $error("setup unanswered");
    property p_inAccess; pready |-> psel && penable; endproperty
    a_inAccess: assert property (p_inAccess) else $error("stray ready");
    property p_onePulse; pready |=> !pready; endproperty
    a_onePulse: assert property (p_onePulse) else $error("ready too long");
    property p_errReady; pslverr |-> pready; endproperty
    a_errReady: assert property (p_errReady) else $error("lone error");
    property p_errZero; pready && pslverr && !pwrite |-> prdata == 32'h0;
    endproperty
    a_errZero: assert property (p_errZero) else $error("refused read data");
    property p_width; pready && !pwrite |-> prdata[31:WIDTH] == '0;
    endproperty
    a_width: assert property (p_width) else $error("upper bits set")
        ;
    // Flags fall only through a bus write, one cycle after it
    property p_flagHeld;
        overflowIrq && !psel && !$past(psel) |=> overflowIrq;
    endproperty
    a_flagHeld: assert property (p_flagHeld) else $error("flag lost")
        ;
    property p_irqHeld; irqOut && !psel && !$past(psel) |=> irqOut;
    endproperty
    a_irqHeld: assert property (p_irqHeld) else $error("irq lost");
    property p_quiet; $fell(sys_rst) |-> !irqOut && !overflowIrq; endproperty
    a_quiet: assert property (p_quiet) else $error("irq out of reset");
endmodule
bind timer8_shared_prescaler timer8_shared_prescaler_monitor #(.WIDTH(WIDTH))
    mon_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .overflowIrq(overflowIrq), .irqOut(irqOut));

/* File: dv/tb_timer8_shared_prescaler.sv */
// Self-checking bench of the shared-prescaler 8-bit timer
`timescale 1ns/1ps
`include "timer8_regs.vh"
module tb_timer8_shared_prescaler;
    logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic        sleepMode, wdClr, overflowIrq, irqOut, extCountInput, err;
    logic        wdtTick;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  a;
    int          nMismatch, testsRun;
    int          cyc = 0;
    timer8_shared_prescaler dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .extCountInput(extCountInput), .sleepMode(sleepMode),
        .watchdogClearOp(wdClr), .overflowIrq(overflowIrq),
        .irqOut(irqOut), .wdtTick(wdtTick));
    ext_pulse_src src_u (.clk(clk), .pin(extCountInput));
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task automatic conclude;
        $display("mismatches %0d compares %0d", nMismatch, testsRun);
        if (nMismatch == 0 && testsRun > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            nMismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus master holds the request until ready is sampled high
    task automatic xfer(input logic w, input logic [11:0] ad,
                        input logic [31:0] d);
        int i;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'h1 && i < 16);
        if (pready !== 1'h1) begin
            nMismatch++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic regReset;
        xfer(1'h0, `ADDR_OPTION_CONFIG, 32'h0);
        cmp(rd, 32'hFF);
        xfer(1'h1, 12'h0FC, 32'h1);
        cmp({31'h0, err}, 32'h1);
        clrPulse();
    endtask
    // Watchdog clear instruction as a one-cycle pulse
    task automatic clrPulse;
        wdClr <= 1'h1;
        @(posedge clk);
        wdClr <= 1'h0;
    endtask
    // Timer to watchdog hand-over, then a clear restarts the watchdog tap
    task automatic wdtClear;
        clrPulse();
        xfer(1'h1, `ADDR_COUNT_VALUE, 32'h0);
        xfer(1'h1, `ADDR_OPTION_CONFIG, 32'h0F);
        clrPulse();
        xfer(1'h1, `ADDR_OPTION_CONFIG, 32'h0F);
        clrPulse();
        repeat (240) @(posedge clk);
        cmp({31'h0, wdtTick}, 32'h0);
        repeat (30) @(posedge clk);
        cmp({31'h0, wdtTick}, 32'h1);
    endtask
    // Reads spaced by whole periods make the phase drop out
    task automatic rate(input logic [7:0] opt, input int per);
        int t;
        xfer(1'h1, `ADDR_OPTION_CONFIG, {24'h0, opt});
        xfer(1'h1, `ADDR_COUNT_VALUE, 32'h0);
        repeat (12) @(posedge clk);
        t = cyc;
        xfer(1'h0, `ADDR_COUNT_VALUE, 32'h0);
        a = rd[7:0];
        while (cyc < t + 2 * per) @(posedge clk);
        xfer(1'h0, `ADDR_COUNT_VALUE, 32'h0);
        cmp({24'h0, rd[7:0] - a}, 32'h2);
    endtask
    task automatic holdAndClear;
        xfer(1'h1, `ADDR_OPTION_CONFIG, 32'h0F);
        xfer(1'h1, `ADDR_COUNT_VALUE, 32'h10);
        repeat (3) @(posedge clk);
        xfer(1'h0, `ADDR_COUNT_VALUE, 32'h0);
        cmp(rd, 32'h10);
        clrPulse();
        xfer(1'h1, `ADDR_OPTION_CONFIG, 32'h07);
        xfer(1'h1, `ADDR_COUNT_VALUE, 32'h0);
        // Under half a prescaler turn, so only a clear delays the next step
        repeat (400) @(posedge clk);
        xfer(1'h1, `ADDR_COUNT_VALUE, 32'h0);
        repeat (300) @(posedge clk);
        xfer(1'h0, `ADDR_COUNT_VALUE, 32'h0);
        cmp(rd, 32'h0);
    endtask
    task automatic overflow;
        xfer(1'h1, `ADDR_OPTION_CONFIG, 32'h0F);
        xfer(1'h1, `ADDR_COUNT_VALUE, 32'hFE);
        repeat (24) @(posedge clk);
        xfer(1'h0, `ADDR_INT_CONTROL, 32'h0);
        cmp(rd, 32'h04);
        cmp({31'h0, overflowIrq}, 32'h0);
        xfer(1'h1, `ADDR_INT_CONTROL, 32'h24);
        @(posedge clk);
        cmp({31'h0, overflowIrq}, 32'h1);
        xfer(1'h1, `ADDR_IRQ_MASK, 32'h1);
        @(posedge clk);
        cmp({31'h0, irqOut}, 32'h1);
        xfer(1'h1, `ADDR_IRQ_STATUS, 32'h1);
        @(posedge clk);
        cmp({31'h0, irqOut}, 32'h0);
        xfer(1'h1, `ADDR_INT_CONTROL, 32'h20);
        @(posedge clk);
        cmp({31'h0, overflowIrq}, 32'h0);
    endtask
    task automatic sleepFreeze;
        sleepMode <= 1'h1;
        xfer(1'h0, `ADDR_COUNT_VALUE, 32'h0);
        a = rd[7:0];
        repeat (40) @(posedge clk);
        xfer(1'h0, `ADDR_COUNT_VALUE, 32'h0);
        cmp(rd, {24'h0, a});
        sleepMode <= 1'h0;
    endtask
    task automatic pinCount(input logic [7:0] opt, input int n, exp);
        xfer(1'h1, `ADDR_OPTION_CONFIG, {24'h0, opt});
        xfer(1'h1, `ADDR_COUNT_VALUE, 32'h0);
        repeat (12) @(posedge clk);
        src_u.toggle(n);
        repeat (12) @(posedge clk);
        xfer(1'h0, `ADDR_COUNT_VALUE, 32'h0);
        cmp(rd, exp);
    endtask
    initial begin
        {psel, penable, pwrite, sleepMode, wdClr} = 5'h0;
        {paddr, pwdata, nMismatch, testsRun} = '0;
        sys_rst = 1'h1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'h0;
        @(posedge clk);
        regReset();
        for (int r = 0; r < 8; r++) rate(r[7:0], 8 << r);
        wdtClear();
        rate(8'h0F, 4);
        overflow();
        sleepFreeze();
        pinCount(8'h28, 11, 6);
        pinCount(8'h38, 9, 5);
        holdAndClear();
        conclude();
    end
    initial begin
        repeat (100000) @(posedge clk);
        nMismatch++;
        conclude();
    end
endmodule
